/* File: sjtp_pkg.sv */
// Package with constants and types for the SRAM test access port
package sjtp_pkg;

    // ****************************************************************
    // Register sizes
    // ****************************************************************
    localparam int SJTP_IR_W = 3;
    localparam int SJTP_ID_W = 32;
    localparam int SJTP_BSR_W = 109;
    localparam int SJTP_RST_HIGHS = 5;

    // ****************************************************************
    // Instruction codes
    // ****************************************************************
    localparam logic [2:0] SJTP_INS_EXTEST = 3'h0;
    localparam logic [2:0] SJTP_INS_IDCODE = 3'h1;
    localparam logic [2:0] SJTP_INS_SAMPLE = 3'h2;
    localparam logic [2:0] SJTP_INS_BYPASS = 3'h7;
    localparam logic [2:0] SJTP_IR_RESET = SJTP_INS_IDCODE;
    localparam logic [1:0] SJTP_IR_CAPTURE = 2'h1;

    // Identification word; value is arbitrary
    localparam logic [31:0] SJTP_IDCODE_DEFAULT = 32'h1234_5679;

    // ****************************************************************
    // Controller states
    // ****************************************************************
    typedef enum logic [3:0] {
        SJTP_TLR, SJTP_RTI, SJTP_SEL_DR, SJTP_CAP_DR, SJTP_SH_DR, SJTP_EX1_DR,
        SJTP_PA_DR, SJTP_EX2_DR, SJTP_UP_DR, SJTP_SEL_IR, SJTP_CAP_IR,
        SJTP_SH_IR, SJTP_EX1_IR, SJTP_PA_IR, SJTP_EX2_IR, SJTP_UP_IR
    } sjtp_state_t;

    // Serial output pin group
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } sjtp_tdo_t;

endpackage

/* File: sjtp_fsm.sv */
// Test access controller state machine
module sjtp_fsm
    import sjtp_pkg::*;
(
    input wire logic tck,
    input wire logic resetn,
    input wire logic tms,
    output sjtp_state_t state_q
);

    sjtp_state_t state_d;

    // Next state from mode select
    always_comb
    begin
        case (state_q)
            SJTP_TLR: state_d = tms ? SJTP_TLR : SJTP_RTI;
            SJTP_RTI: state_d = tms ? SJTP_SEL_DR : SJTP_RTI;
            SJTP_SEL_DR: state_d = tms ? SJTP_SEL_IR : SJTP_CAP_DR;
            SJTP_CAP_DR: state_d = tms ? SJTP_EX1_DR : SJTP_SH_DR;
            SJTP_SH_DR: state_d = tms ? SJTP_EX1_DR : SJTP_SH_DR;
            SJTP_EX1_DR: state_d = tms ? SJTP_UP_DR : SJTP_PA_DR;
            SJTP_PA_DR: state_d = tms ? SJTP_EX2_DR : SJTP_PA_DR;
            SJTP_EX2_DR: state_d = tms ? SJTP_UP_DR : SJTP_SH_DR;
            SJTP_UP_DR: state_d = tms ? SJTP_SEL_DR : SJTP_RTI;
            SJTP_SEL_IR: state_d = tms ? SJTP_TLR : SJTP_CAP_IR;
            SJTP_CAP_IR: state_d = tms ? SJTP_EX1_IR : SJTP_SH_IR;
            SJTP_SH_IR: state_d = tms ? SJTP_EX1_IR : SJTP_SH_IR;
            SJTP_EX1_IR: state_d = tms ? SJTP_UP_IR : SJTP_PA_IR;
            SJTP_PA_IR: state_d = tms ? SJTP_EX2_IR : SJTP_PA_IR;
            SJTP_EX2_IR: state_d = tms ? SJTP_UP_IR : SJTP_SH_IR;
            SJTP_UP_IR: state_d = tms ? SJTP_SEL_DR : SJTP_RTI;
            default: state_d = SJTP_TLR;
        endcase
    end

    // State register, reset at power-up
    always_ff @(posedge tck or negedge resetn)
    begin
        if (!resetn)
            state_q <= SJTP_TLR;
        else
            state_q <= state_d;
    end

endmodule

/* File: sjtp_tap.sv */
// Top of the SRAM boundary-scan test access port
module sjtp_tap
    import sjtp_pkg::*;
#(
    parameter int BSR_W = SJTP_BSR_W,
    parameter logic [31:0] IDCODE = SJTP_IDCODE_DEFAULT
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic [BSR_W-1:0] ring_in,
    output logic tdo,
    output logic tdo_oe,
    output logic [SJTP_IR_W-1:0] instr_sys
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (BSR_W < 2)
        $error("boundary register too short");
    if (IDCODE[0] != 1'b1)
        $error("identification word needs bit 0 set");

    sjtp_state_t state_q;
    logic [SJTP_IR_W-1:0] ir_sh_q;
    logic [SJTP_IR_W-1:0] ir_q;
    logic byp_q;
    logic [SJTP_ID_W-1:0] id_q;
    logic [BSR_W-1:0] bsr_q;
    logic [BSR_W-1:0] ring_s1_q;
    logic [BSR_W-1:0] ring_s2_q;
    logic [SJTP_IR_W-1:0] ins_s1_q;
    logic [SJTP_IR_W-1:0] ins_s2_q;
    logic [SJTP_IR_W-1:0] ins_s3_q;
    logic sel_out;
    sjtp_tdo_t out_d;

    // ****************************************************************
    // Controller
    // ****************************************************************
    sjtp_fsm u_fsm (
        .tck(tck),
        .resetn(resetn),
        .tms(tms),
        .state_q(state_q)
    );

    // Device ring synchronised into the test clock domain
    always_ff @(posedge tck or negedge resetn)
    begin
        if (!resetn)
        begin
            ring_s1_q <= '0;
            ring_s2_q <= '0;
        end
        else
        begin
            ring_s1_q <= ring_in;
            ring_s2_q <= ring_s1_q;
        end
    end

    // ****************************************************************
    // Instruction register
    // ****************************************************************
    always_ff @(posedge tck or negedge resetn)
    begin
        if (!resetn)
            ir_q <= SJTP_IR_RESET;
        else if (state_q == SJTP_TLR)
            ir_q <= SJTP_IR_RESET;
        else if (state_q == SJTP_UP_IR)
            ir_q <= ir_sh_q;
    end

    // Instruction shift stage
    always_ff @(posedge tck or negedge resetn)
    begin
        if (!resetn)
            ir_sh_q <= '0;
        else if (state_q == SJTP_CAP_IR)
            ir_sh_q <= {1'b0, SJTP_IR_CAPTURE};
        else if (state_q == SJTP_SH_IR)
            ir_sh_q <= {tdi, ir_sh_q[SJTP_IR_W-1:1]};
    end

    // ****************************************************************
    // Data registers
    // ****************************************************************
    // Bypass bit
    always_ff @(posedge tck or negedge resetn)
    begin
        if (!resetn)
            byp_q <= 1'b0;
        else if (state_q == SJTP_CAP_DR)
            byp_q <= 1'b0;
        else if (state_q == SJTP_SH_DR)
            byp_q <= tdi;
    end

    // Identification register
    always_ff @(posedge tck or negedge resetn)
    begin
        if (!resetn)
            id_q <= '0;
        else if (state_q == SJTP_CAP_DR && ir_q == SJTP_INS_IDCODE)
            id_q <= IDCODE;
        else if (state_q == SJTP_SH_DR && ir_q == SJTP_INS_IDCODE)
            id_q <= {tdi, id_q[SJTP_ID_W-1:1]};
    end

    // Boundary register, used by sample and external test
    always_ff @(posedge tck or negedge resetn)
    begin
        if (!resetn)
            bsr_q <= '0;
        else if (state_q == SJTP_CAP_DR && (ir_q == SJTP_INS_SAMPLE || ir_q == SJTP_INS_EXTEST))
            bsr_q <= ring_s2_q;
        else if (state_q == SJTP_SH_DR && (ir_q == SJTP_INS_SAMPLE || ir_q == SJTP_INS_EXTEST))
            bsr_q <= {tdi, bsr_q[BSR_W-1:1]};
    end

    // ****************************************************************
    // Output path
    // ****************************************************************
    // Register selection by state and instruction
    always_comb
    begin
        case (ir_q)
            SJTP_INS_IDCODE: sel_out = id_q[0];
            SJTP_INS_SAMPLE: sel_out = bsr_q[0];
            SJTP_INS_EXTEST: sel_out = bsr_q[0];
            default: sel_out = byp_q;
        endcase
        out_d.tdo = (state_q == SJTP_SH_IR) ? ir_sh_q[0] : sel_out;
        out_d.tdo_oe = (state_q == SJTP_SH_IR) || (state_q == SJTP_SH_DR);
    end

    // Output launched on the falling test clock edge
    always_ff @(negedge tck or negedge resetn)
    begin
        if (!resetn)
        begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else
        begin
            tdo <= out_d.tdo;
            tdo_oe <= out_d.tdo_oe;
        end
    end

    // ****************************************************************
    // Instruction handed to the system clock domain
    // ****************************************************************
    // Two sync stages, then a stability filter past the second stage
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ins_s1_q <= SJTP_IR_RESET;
            ins_s2_q <= SJTP_IR_RESET;
            ins_s3_q <= SJTP_IR_RESET;
            instr_sys <= SJTP_IR_RESET;
        end
        else
        begin
            ins_s1_q <= ir_q;
            ins_s2_q <= ins_s1_q;
            ins_s3_q <= ins_s2_q;
            if (ins_s3_q == ins_s2_q)
                instr_sys <= ins_s3_q; // Skewed bits never pass two samples
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [2:0] high_cnt_q;
    logic tdo_rise_q;

    // Count of consecutive high mode selects, saturating
    always_ff @(posedge tck or negedge resetn)
    begin
        if (!resetn)
            high_cnt_q <= '0;
        else if (!tms)
            high_cnt_q <= '0;
        else if (high_cnt_q != 3'(SJTP_RST_HIGHS))
            high_cnt_q <= high_cnt_q + 3'h1;
    end

    // Serial output as seen at each rising edge
    always_ff @(posedge tck or negedge resetn)
    begin
        if (!resetn)
            tdo_rise_q <= 1'b0;
        else
            tdo_rise_q <= tdo;
    end

    chk_five_high_reset: assert property (@(posedge tck) disable iff (!resetn)
        high_cnt_q == 3'(SJTP_RST_HIGHS) |-> state_q == SJTP_TLR)
        else $error("five high mode selects did not reset controller");
    chk_ir_preload: assert property (@(posedge tck) disable iff (!resetn)
        state_q == SJTP_TLR |=> ir_q == SJTP_IR_RESET)
        else $error("instruction not preloaded in reset state");
    chk_id_capture: assert property (@(posedge tck) disable iff (!resetn)
        state_q == SJTP_CAP_DR && ir_q == SJTP_INS_IDCODE |=> id_q == IDCODE)
        else $error("identification not captured");
    chk_id_shift: assert property (@(posedge tck) disable iff (!resetn)
        state_q == SJTP_SH_DR && ir_q == SJTP_INS_IDCODE |=> id_q[31] == $past(tdi))
        else $error("identification shift lost input bit");
    chk_bypass_shift: assert property (@(posedge tck) disable iff (!resetn)
        state_q == SJTP_SH_DR |=> byp_q == $past(tdi))
        else $error("bypass bit did not take serial input");
    chk_oe_shift: assert property (@(negedge tck) disable iff (!resetn)
        tdo_oe |-> $past(state_q == SJTP_SH_DR || state_q == SJTP_SH_IR))
        else $error("output enabled outside shift");
    chk_tdo_stable: assert property (@(negedge tck) disable iff (!resetn)
        tdo == tdo_rise_q)
        else $error("serial output changed on rising edge");
    chk_ir_update: assert property (@(posedge tck) disable iff (!resetn)
        state_q == SJTP_UP_IR |=> ir_q == $past(ir_sh_q))
        else $error("instruction not updated");
    chk_bsr_capture: assert property (@(posedge tck) disable iff (!resetn)
        state_q == SJTP_CAP_DR && ir_q == SJTP_INS_SAMPLE |=> bsr_q == $past(ring_s2_q))
        else $error("boundary capture wrong");

    cov_id_read: cover property (@(posedge tck) disable iff (!resetn)
        state_q == SJTP_SH_DR && ir_q == SJTP_INS_IDCODE);
    cov_bypass: cover property (@(posedge tck) disable iff (!resetn)
        state_q == SJTP_SH_DR && ir_q == SJTP_INS_BYPASS);
    cov_sample: cover property (@(posedge tck) disable iff (!resetn)
        state_q == SJTP_SH_DR && ir_q == SJTP_INS_SAMPLE);
    cov_ir_load: cover property (@(posedge tck) disable iff (!resetn)
        state_q == SJTP_UP_IR);

endmodule

/* File: sjtp_tester.sv */
// Behavioural model of the external boundary-scan tester
module sjtp_tester
(
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // Pin drive and line view
    // ****************************************************************
    logic last_q;
    wire logic pin_line;

    // Released line shows the inverse of its last driven level
    assign pin_line = tdo_oe ? tdo : ~last_q;

    // Idle levels; test clock stands still between frames
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        last_q = 1'b0;
    end

    // Remember the last driven output level
    always @(posedge tck)
        if (tdo_oe)
            last_q <= tdo;

    // One test clock: set up, rise, sample, release data, fall
    task automatic step(input logic m, input logic d, output logic o, output logic oe);
        tms = m;
        tdi = d;
        #80 tck = 1'b1;
        o = pin_line;
        oe = tdo_oe;
        #20 tdi = ~d;
        #60 tck = 1'b0;
    endtask
endmodule

/* File: sjtp_tap_test.sv */
// Self-checking bench for the SRAM test access port
module sjtp_tap_test
    import sjtp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    localparam int BW = SJTP_BSR_W;
    localparam logic [31:0] TB_ID = 32'h0a5c_3e71; // Arbitrary identification value
    logic clk;
    logic resetn;
    logic [BW-1:0] ring_in;
    wire logic tck;
    wire logic tms;
    wire logic tdi;
    wire logic tdo;
    wire logic tdo_oe;
    wire logic [SJTP_IR_W-1:0] instr_sys;
    int err_total;
    int check_count;

    sjtp_tap #(.BSR_W(BW), .IDCODE(TB_ID)) uut (.clk(clk), .resetn(resetn), .tck(tck),
        .tms(tms), .tdi(tdi), .ring_in(ring_in), .tdo(tdo), .tdo_oe(tdo_oe),
        .instr_sys(instr_sys));
    sjtp_tester tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    // System clock, 50 ns period
    always #25 clk = ~clk;

    // Serial output may only move after a falling test clock
    always @(tdo)
        if (resetn === 1'b1)
            check(tck, 1'b0);

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // From idle: walk into a shift state, shift n bits, return to idle
    task automatic scan(input logic ir, input int n, input logic [BW-1:0] din,
                        output logic [BW-1:0] dout);
        logic o;
        logic oe;
        dout = '0;
        tst.step(1'b1, 1'b0, o, oe);
        if (ir)
            tst.step(1'b1, 1'b0, o, oe);
        tst.step(1'b0, 1'b0, o, oe);
        tst.step(1'b0, 1'b0, o, oe);
        for (int i = 0; i < n; i++)
        begin
            tst.step(i == n - 1, din[i], o, oe);
            dout[i] = o;
            check(oe, 1'b1);
        end
        tst.step(1'b1, 1'b0, o, oe);
        check(oe, 1'b0);
        tst.step(1'b0, 1'b0, o, oe);
    endtask

    // Bounded wait for the system-side instruction view
    task automatic wait_instr(input logic [2:0] exp);
        for (int k = 0; k < 40 && instr_sys !== exp; k++)
            @(negedge clk);
        check(instr_sys, exp);
        if (instr_sys !== exp)
            tally_and_finish();
    endtask

    task automatic load_ir(input logic [2:0] code);
        logic [BW-1:0] d;
        scan(1'b1, 3, BW'(code), d);
        check(d[2:0], {1'b0, SJTP_IR_CAPTURE});
        wait_instr(code);
    endtask

    task automatic read_id();
        logic [BW-1:0] d;
        logic o;
        logic oe;
        tst.step(1'b0, 1'b0, o, oe);
        check(oe, 1'b0);
        scan(1'b0, 32, '0, d);
        check(d[31:0], TB_ID);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset_id();
        check(tdo_oe, 1'b0);
        check(instr_sys, SJTP_IR_RESET);
        read_id();
    endtask

    // Bypass and undefined codes pass data one bit late
    task automatic t_bypass(input logic [2:0] code);
        logic [BW-1:0] d;
        load_ir(code);
        scan(1'b0, 8, BW'(8'hb5), d);
        check(d[7:0], 8'h6a);
    endtask

    // Boundary register captures the ring, then shifts out
    task automatic t_boundary(input logic [2:0] code, input logic [BW-1:0] ring);
        logic [BW-1:0] d;
        @(negedge clk);
        ring_in = ring;
        load_ir(code);
        scan(1'b0, BW, '0, d);
        check(d, ring);
    endtask

    // Five highs reach reset with the instruction kept; a sixth clock loads the preload
    task automatic t_tms_reset();
        logic o;
        logic oe;
        load_ir(SJTP_INS_BYPASS);
        tst.step(1'b1, 1'b0, o, oe);
        tst.step(1'b0, 1'b0, o, oe);
        tst.step(1'b0, 1'b0, o, oe);
        repeat (5) tst.step(1'b1, 1'b0, o, oe);
        repeat (20) @(negedge clk);
        check(instr_sys, SJTP_INS_BYPASS);
        tst.step(1'b1, 1'b0, o, oe);
        wait_instr(SJTP_IR_RESET);
        read_id();
    endtask

    // Power-up reset in the middle of an instruction shift
    task automatic t_power_reset();
        logic o;
        logic oe;
        load_ir(SJTP_INS_BYPASS);
        tst.step(1'b1, 1'b0, o, oe);
        tst.step(1'b1, 1'b0, o, oe);
        tst.step(1'b0, 1'b0, o, oe);
        tst.step(1'b0, 1'b0, o, oe);
        tst.step(1'b0, 1'b1, o, oe);
        @(negedge clk);
        resetn = 1'b0;
        tst.step(1'b1, 1'b0, o, oe);
        @(negedge clk);
        check(tdo_oe, 1'b0);
        check(instr_sys, SJTP_IR_RESET);
        resetn = 1'b1;
        read_id();
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic o;
        logic oe;
        clk = 1'b0;
        resetn = 1'b0;
        ring_in = '0;
        err_total = 0;
        check_count = 0;
        fork
            tst.step(1'b1, 1'b0, o, oe);
            repeat (20) @(negedge clk);
        join
        resetn = 1'b1;
        t_reset_id();
        t_bypass(SJTP_INS_BYPASS);
        t_bypass(3'h5);
        t_boundary(SJTP_INS_SAMPLE, {5'h15, {13{8'hc3}}});
        t_boundary(SJTP_INS_EXTEST, ~{5'h15, {13{8'hc3}}});
        t_tms_reset();
        t_power_reset();
        tally_and_finish();
    end
endmodule
